// >>> hdl/lbo_pkg.sv
// Constants, field layouts and carrier types for the link/output config regs
// Notes on behaviour
// RULE1: Local ack bit (reset 1) makes bridge slave ack locally while link down.
// RULE2: Slave setup/hold field picks 352/117..1046/469 ns; resets to 01.
// RULE3: Master rate field picks 8.47..837 kbps typical; resets to 101.
// RULE4: Remote timeout field picks 64/256/1024 us or off; resets to 10.
// RULE5: Master timeout disable bit set to 1 switches master timeout off.
// RULE6: Sync position field moves HS/VS to bits 18/19, 14/15 or 0/1.
// RULE7: Empty audio FIFO repeats last word at 0, outputs zeros at 1.
// RULE8: Serial clock invert bit inverts SCK at output when set.
// RULE9: Word select invert bit inverts WS at output when set.
// RULE10: Registers load defaults at reset, hold writes; reserved bit reads 0.
package lbo_pkg;
  // Byte offsets; printed offsets are not word multiples, so index times 4
  localparam logic [7:0] LBO_IDX_BRIDGE = 8'h1C;
  localparam logic [7:0] LBO_IDX_OUTFMT = 8'h1D;
  localparam logic [9:0] LBO_ADR_BRIDGE = {LBO_IDX_BRIDGE, 2'b00};
  localparam logic [9:0] LBO_ADR_OUTFMT = {LBO_IDX_OUTFMT, 2'b00};
  // Field positions, bridge_timing_control
  localparam int LBO_LOCACK_BIT  = 7;
  localparam int LBO_SETHLD_LSB  = 5;
  localparam int LBO_RATE_LSB    = 2;
  localparam int LBO_RTO_LSB     = 0;
  // Field positions, output_format_control
  localparam int LBO_MTODIS_BIT  = 7;
  localparam int LBO_RSVD_BIT    = 6;
  localparam int LBO_DESRC_BIT   = 5;
  localparam int LBO_SYNCPOS_LSB = 3;
  localparam int LBO_AUDEMPTY_BIT = 2;
  localparam int LBO_SCKINV_BIT  = 1;
  localparam int LBO_WSINV_BIT   = 0;
  // Reset values: 1,01,101,10 and all zero
  localparam logic [7:0] LBO_RST_BRIDGE = 8'hB6;
  localparam logic [7:0] LBO_RST_OUTFMT = 8'h00;
  // Writable bits of output_format_control (reserved and DE-source excluded)
  localparam logic [7:0] LBO_MASK_OUTFMT = 8'h9F;
  // Setup/hold times in ns per code, and timeouts in us
  localparam int LBO_SETUP_NS [4] = '{352, 469, 938, 1046};
  localparam int LBO_HOLD_NS  [4] = '{117, 234, 352, 469};
  localparam int LBO_RTO_US   [3] = '{64, 256, 1024};
  // Typical master bit rates in bits per second per code
  localparam int LBO_RATE_BPS [8] = '{8470, 28300, 84700, 105000,
                                     173000, 339000, 533000, 837000};
  localparam int LBO_CLK_HZ = 50_000_000;
  localparam int LBO_CLK_NS = 20;
  // Cycle counts: least times round up, the bit period rounds down
  localparam int LBO_CNT_W = 17;
  // Remote timeout off code
  localparam logic [1:0] LBO_RTO_OFF = 2'b11;

  // Decoded bridge settings
  typedef struct packed {
    logic                 local_ack_enable;
    logic [LBO_CNT_W-1:0] setup_cycles;
    logic [LBO_CNT_W-1:0] hold_cycles;
    logic [LBO_CNT_W-1:0] bit_period_cycles;
    logic                 remote_timeout_on;
    logic [LBO_CNT_W-1:0] remote_timeout_cycles;
    logic                 master_timeout_on;
  } lbo_bridge_cfg_t;

  // Video word with its sync bits
  typedef struct packed {
    logic [19:0] data;
  } lbo_video_t;

  // Audio serial lines
  typedef struct packed {
    logic sck;
    logic ws;
  } lbo_audio_t;
endpackage

// >>> hdl/lbo_bridge_decode.sv
// Decoder that turns bridge register fields into cycle counts
`timescale 1ns/1ns
module lbo_bridge_decode
  import lbo_pkg::*;
(
  input  wire logic [7:0]      i_bridge_reg,
  input  wire logic            i_mto_disable,
  output lbo_pkg::lbo_bridge_cfg_t o_cfg
);
  // Count tables built at elaboration: time in ns over clock period
  localparam int SET_C [4] = '{(LBO_SETUP_NS[0]+LBO_CLK_NS-1)/LBO_CLK_NS,
                               (LBO_SETUP_NS[1]+LBO_CLK_NS-1)/LBO_CLK_NS,
                               (LBO_SETUP_NS[2]+LBO_CLK_NS-1)/LBO_CLK_NS,
                               (LBO_SETUP_NS[3]+LBO_CLK_NS-1)/LBO_CLK_NS};
  localparam int HLD_C [4] = '{(LBO_HOLD_NS[0]+LBO_CLK_NS-1)/LBO_CLK_NS,
                               (LBO_HOLD_NS[1]+LBO_CLK_NS-1)/LBO_CLK_NS,
                               (LBO_HOLD_NS[2]+LBO_CLK_NS-1)/LBO_CLK_NS,
                               (LBO_HOLD_NS[3]+LBO_CLK_NS-1)/LBO_CLK_NS};
  localparam int RTO_C [3] = '{LBO_RTO_US[0]*1000/LBO_CLK_NS,
                               LBO_RTO_US[1]*1000/LBO_CLK_NS,
                               LBO_RTO_US[2]*1000/LBO_CLK_NS};

  wire logic [1:0] sh_code   = i_bridge_reg[LBO_SETHLD_LSB +: 2];
  wire logic [2:0] rate_code = i_bridge_reg[LBO_RATE_LSB +: 3];
  wire logic [1:0] rto_code  = i_bridge_reg[LBO_RTO_LSB +: 2];

  // Rate table lookup; the bit period is a longest time, so it rounds down
  function automatic logic [LBO_CNT_W-1:0] rate_cycles(input logic [2:0] c);
    int v;
    v = LBO_CLK_HZ / LBO_RATE_BPS[c];
    return v[LBO_CNT_W-1:0];
  endfunction

  // Plain field decode, no state
  assign o_cfg.local_ack_enable  = i_bridge_reg[LBO_LOCACK_BIT];   // [RULE1]
  assign o_cfg.setup_cycles      = SET_C[sh_code][LBO_CNT_W-1:0];  // [RULE2]
  assign o_cfg.hold_cycles       = HLD_C[sh_code][LBO_CNT_W-1:0];  // [RULE2]
  assign o_cfg.bit_period_cycles = rate_cycles(rate_code);         // [RULE3]
  assign o_cfg.remote_timeout_on = (rto_code != LBO_RTO_OFF);      // [RULE4]
  assign o_cfg.remote_timeout_cycles = (rto_code == LBO_RTO_OFF) ?
         '0 : RTO_C[rto_code][LBO_CNT_W-1:0];                       // [RULE4]
  assign o_cfg.master_timeout_on = ~i_mto_disable;                 // [RULE5]
endmodule

// >>> hdl/lbo_config_regs.sv
// Wishbone register bank for bridge timing and output format control
`timescale 1ns/1ns
module lbo_config_regs
  import lbo_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  // Wishbone classic slave
  input  wire logic               i_wb_cyc,
  input  wire logic               i_wb_stb,
  input  wire logic               i_wb_we,
  input  wire logic [9:0]         i_wb_adr,
  input  wire logic [31:0]        i_wb_dat,
  input  wire logic [3:0]         i_wb_sel,
  output logic      [31:0]        o_wb_dat,
  output logic                    o_wb_ack,
  // Bridge side
  input  wire logic               i_fwd_link_up,
  input  wire logic               i_bridge_req,
  output logic                    o_local_ack,
  output lbo_pkg::lbo_bridge_cfg_t o_bridge_cfg,
  // Video path
  input  lbo_pkg::lbo_video_t     i_video,
  output lbo_pkg::lbo_video_t     o_video,
  // Audio path
  input  wire logic               i_aud_empty,
  input  wire logic               i_aud_valid,
  input  wire logic [31:0]        i_aud_word,
  output logic      [31:0]        o_aud_word,
  input  lbo_pkg::lbo_audio_t     i_aud_lines,
  output lbo_pkg::lbo_audio_t     o_aud_lines
);
  import lbo_pkg::*;

  logic [7:0]  bridge_ff;
  logic [7:0]  outfmt_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] aud_ff;
  logic [31:0] last_ff;
  lbo_video_t  video_ff;
  lbo_audio_t  lines_ff;
  logic        lack_ff;

  // Address decode; only byte lane 0 carries the 8-bit registers
  wire logic       req      = i_wb_cyc & i_wb_stb & ~ack_ff;
  wire logic       hit_brg  = (i_wb_adr == LBO_ADR_BRIDGE);
  wire logic       hit_fmt  = (i_wb_adr == LBO_ADR_OUTFMT);
  wire logic       wr_lane  = req & i_wb_we & i_wb_sel[0];
  wire logic       wr_brg   = wr_lane & hit_brg;
  wire logic       wr_fmt   = wr_lane & hit_fmt;
  wire logic [7:0] nxt_bridge = wr_brg ? i_wb_dat[7:0] : bridge_ff;
  wire logic [7:0] nxt_outfmt = wr_fmt ? (i_wb_dat[7:0] & LBO_MASK_OUTFMT)
                                       : outfmt_ff;
  // Unmapped addresses still ack and read zero, so a master never hangs
  wire logic [7:0] rd_byte  = hit_brg ? bridge_ff :
                              hit_fmt ? outfmt_ff : 8'h00;
  wire logic [31:0] nxt_rdat = {24'h000000, rd_byte};

  // Register storage
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      bridge_ff <= LBO_RST_BRIDGE;                      // [RULE10]
      outfmt_ff <= LBO_RST_OUTFMT;                      // [RULE10]
    end else begin
      bridge_ff <= nxt_bridge;                          // [RULE10]
      outfmt_ff <= nxt_outfmt;                          // [RULE10]
    end
  end

  // Bus answer: one wait cycle, ack then drop
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff  <= req;
      rdat_ff <= req ? nxt_rdat : rdat_ff;
    end
  end
  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;

  // Field views
  wire logic       mto_dis  = outfmt_ff[LBO_MTODIS_BIT];
  wire logic [1:0] sync_pos = outfmt_ff[LBO_SYNCPOS_LSB +: 2];
  wire logic       aud_zero = outfmt_ff[LBO_AUDEMPTY_BIT];
  wire logic       sck_inv  = outfmt_ff[LBO_SCKINV_BIT];
  wire logic       ws_inv   = outfmt_ff[LBO_WSINV_BIT];

  lbo_bridge_decode u_decode (
    .i_bridge_reg  (bridge_ff),
    .i_mto_disable (mto_dis),
    .o_cfg         (o_bridge_cfg)
  );

  // Local ack only when the link is down and software allows it
  wire logic nxt_lack = i_bridge_req & ~i_fwd_link_up &
                        bridge_ff[LBO_LOCACK_BIT];      // [RULE1]

  // Sync repositioning; 1X also inverts HS/VS
  wire logic [19:0] vin = i_video.data;
  // For 01: data 17:14 rises to 19:16, HS/VS drop to 15:14
  wire logic [19:0] v_01 = {vin[17:14], vin[19:18], vin[13:0]};
  // For 1X: data 17:0 rises to 19:2, inverted HS/VS at 1:0
  wire logic [19:0] v_1x = {vin[17:0], ~vin[19:18]};
  wire logic [19:0] nxt_video = (sync_pos == 2'b00) ? vin :
                                (sync_pos == 2'b01) ? v_01 :
                                v_1x;                       // [RULE6]

  // Empty FIFO: hold last word or emit zeros
  wire logic [31:0] nxt_aud = ~i_aud_empty ? i_aud_word :
                              aud_zero ? 32'h00000000 : last_ff; // [RULE7]
  wire logic [31:0] nxt_last = (i_aud_valid & ~i_aud_empty) ? i_aud_word
                                                             : last_ff;
  // Output polarity of the serial audio lines
  wire lbo_audio_t nxt_lines = '{sck: i_aud_lines.sck ^ sck_inv,  // [RULE8]
                                 ws:  i_aud_lines.ws  ^ ws_inv};  // [RULE9]

  // Output flops on the data paths
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      video_ff <= '0;
      aud_ff   <= 32'h00000000;
      last_ff  <= 32'h00000000;
      lines_ff <= '0;
      lack_ff  <= 1'b0;
    end else begin
      video_ff <= '{data: nxt_video};
      aud_ff   <= nxt_aud;
      last_ff  <= nxt_last;
      lines_ff <= nxt_lines;
      lack_ff  <= nxt_lack;
    end
  end
  assign o_video     = video_ff;
  assign o_aud_word  = aud_ff;
  assign o_aud_lines = lines_ff;
  assign o_local_ack = lack_ff;

  // Assertions
  property p_reset_vals;
    @(posedge i_clock) $fell(i_rst) |->
      bridge_ff == LBO_RST_BRIDGE && outfmt_ff == LBO_RST_OUTFMT;
  endproperty
  a_reset_vals: assert property (p_reset_vals) // [RULE10]
    else $error("register reset values wrong");

  property p_rsvd_zero;
    @(posedge i_clock) disable iff (i_rst) o_wb_ack && hit_fmt |->
      o_wb_dat[LBO_RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // [RULE10]
    else $error("reserved bit reads nonzero");

  property p_local_ack;
    @(posedge i_clock) disable iff (i_rst)
      i_bridge_req && !i_fwd_link_up |=> o_local_ack == $past(bridge_ff[7]);
  endproperty
  a_local_ack: assert property (p_local_ack) // [RULE1]
    else $error("local ack wrong");

  property p_no_ack_link_up;
    @(posedge i_clock) disable iff (i_rst) i_fwd_link_up |=> !o_local_ack;
  endproperty
  a_no_ack_link_up: assert property (p_no_ack_link_up) // [RULE1]
    else $error("local ack while link up");

  property p_mto;
    @(posedge i_clock) disable iff (i_rst)
      o_bridge_cfg.master_timeout_on == !outfmt_ff[LBO_MTODIS_BIT];
  endproperty
  a_mto: assert property (p_mto) // [RULE5]
    else $error("master timeout state wrong");

  property p_rto_off;
    @(posedge i_clock) disable iff (i_rst)
      bridge_ff[1:0] == 2'b11 |-> !o_bridge_cfg.remote_timeout_on;
  endproperty
  a_rto_off: assert property (p_rto_off) // [RULE4]
    else $error("remote timeout not off");

  property p_sync_norm;
    @(posedge i_clock) disable iff (i_rst)
      sync_pos == 2'b00 |=> o_video.data == $past(i_video.data);
  endproperty
  a_sync_norm: assert property (p_sync_norm) // [RULE6]
    else $error("sync position 00 altered data");

  property p_aud_zero;
    @(posedge i_clock) disable iff (i_rst)
      i_aud_empty && aud_zero |=> o_aud_word == 32'h00000000;
  endproperty
  a_aud_zero: assert property (p_aud_zero) // [RULE7]
    else $error("empty FIFO not zero");

  property p_aud_hold;
    @(posedge i_clock) disable iff (i_rst)
      i_aud_empty && !aud_zero |=> o_aud_word == $past(last_ff);
  endproperty
  a_aud_hold: assert property (p_aud_hold) // [RULE7]
    else $error("empty FIFO did not repeat");

  property p_sck;
    @(posedge i_clock) disable iff (i_rst)
      1'b1 |=> o_aud_lines.sck == ($past(i_aud_lines.sck) ^ $past(sck_inv));
  endproperty
  a_sck: assert property (p_sck) // [RULE8]
    else $error("SCK polarity wrong");

  property p_ws;
    @(posedge i_clock) disable iff (i_rst)
      1'b1 |=> o_aud_lines.ws == ($past(i_aud_lines.ws) ^ $past(ws_inv));
  endproperty
  a_ws: assert property (p_ws) // [RULE9]
    else $error("WS polarity wrong");

  property p_rate_default;
    @(posedge i_clock) disable iff (i_rst)
      bridge_ff[4:2] == 3'b101 |-> o_bridge_cfg.bit_period_cycles == 17'd147;
  endproperty
  a_rate_default: assert property (p_rate_default) // [RULE3]
    else $error("bit period count wrong");

  property p_sethold;
    @(posedge i_clock) disable iff (i_rst)
      bridge_ff[6:5] == 2'b00 |-> o_bridge_cfg.setup_cycles == 17'd18 &&
                                  o_bridge_cfg.hold_cycles == 17'd6;
  endproperty
  a_sethold: assert property (p_sethold) // [RULE2]
    else $error("setup/hold count wrong");
endmodule

// >>> verification/lbo_config_regs_tb.sv
// Self-checking bench for the link/output configuration register bank
`timescale 1ns/1ns
module lbo_config_regs_tb;
  import lbo_pkg::*;
  logic            i_clock = 1'b0;
  logic            i_rst = 1'b1;
  logic            wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [9:0]      wb_adr = '0;
  logic [31:0]     wb_dat = '0;
  logic [3:0]      wb_sel = '0;
  logic [31:0]     o_wb_dat, o_aud_word, rd_dat;
  logic            o_wb_ack, o_local_ack;
  logic            link_up = 1'b1, br_req = 1'b0;
  logic            aud_empty = 1'b1, aud_valid = 1'b0;
  logic [31:0]     aud_word = '0;
  lbo_bridge_cfg_t cfg;
  lbo_video_t      vid_in = '0, vid_out;
  lbo_video_t      vid_seen [4];
  lbo_audio_t      lines_in = '0, lines_out;
  int              fails = 0, total_checks = 0;

  // 50 MHz clock
  always #10 i_clock = ~i_clock;

  lbo_config_regs DUT (.i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(wb_cyc),
    .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_dat(wb_dat),
    .i_wb_sel(wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_fwd_link_up(link_up), .i_bridge_req(br_req),
    .o_local_ack(o_local_ack), .o_bridge_cfg(cfg), .i_video(vid_in),
    .o_video(vid_out), .i_aud_empty(aud_empty), .i_aud_valid(aud_valid),
    .i_aud_word(aud_word), .o_aud_word(o_aud_word), .i_aud_lines(lines_in),
    .o_aud_lines(lines_out));

  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [9:0] adr,
                    input logic [7:0] wd, input logic [3:0] sel);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= {24'h0, wd};
    wb_sel <= sel;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    if (n >= 50) check("wb_ack", {31'h0, o_wb_ack}, 32'h1);
    rd_dat = o_wb_dat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic rchk(input logic [9:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 8'h00, 4'hF);
    check("read data", rd_dat, {24'h0, exp});
  endtask

  task automatic t_reset();
    rchk(LBO_ADR_BRIDGE, 8'hB6);
    rchk(LBO_ADR_OUTFMT, 8'h00);
    check("lack", 32'(cfg.local_ack_enable), 32'h1);
    check("mto", 32'(cfg.master_timeout_on), 32'h1);
    check("rto", 32'(cfg.remote_timeout_cycles), 32'd51200);
    check("setup", 32'(cfg.setup_cycles), 32'd24);
    check("rate", 32'(cfg.bit_period_cycles), 32'd147);
    $display("Test reset values done");
  endtask

  // Reserved and unmapped places, byte enable, master timeout bit
  task automatic t_regs();
    wb(1'b1, LBO_ADR_OUTFMT, 8'hFF, 4'hF);
    rchk(LBO_ADR_OUTFMT, 8'h9F);
    check("mto off", 32'(cfg.master_timeout_on), 32'h0);
    wb(1'b1, LBO_ADR_OUTFMT, 8'h00, 4'hE);
    rchk(LBO_ADR_OUTFMT, 8'h9F);
    wb(1'b1, 10'h078, 8'hFF, 4'hF);
    rchk(10'h078, 8'h00);
    rchk(LBO_ADR_BRIDGE, 8'hB6);
    wb(1'b1, LBO_ADR_OUTFMT, 8'h00, 4'hF);
    check("mto on", 32'(cfg.master_timeout_on), 32'h1);
    $display("Test register access done");
  endtask

  // Every rate code, every setup/hold and timeout code
  task automatic t_bridge();
    logic [2:0] c;
    int         e;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wb(1'b1, LBO_ADR_BRIDGE, {1'b1, c[1:0], c, c[1:0]}, 4'hF);
      e = (LBO_SETUP_NS[c[1:0]] + 19) / 20;
      check("setup", 32'(cfg.setup_cycles), e);
      e = (LBO_HOLD_NS[c[1:0]] + 19) / 20;
      check("hold", 32'(cfg.hold_cycles), e);
      e = LBO_CLK_HZ / LBO_RATE_BPS[c];
      check("rate", 32'(cfg.bit_period_cycles), e);
      check("rto on", 32'(cfg.remote_timeout_on), 32'(c[1:0] != 2'b11));
      if (c[1:0] != 2'b11) begin
        e = LBO_RTO_US[c[1:0]] * 50;
        check("rto", 32'(cfg.remote_timeout_cycles), e);
      end
    end
    $display("Test bridge decode done");
  endtask

  task automatic t_local_ack();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wb(1'b1, LBO_ADR_BRIDGE, {c[2], 7'h36}, 4'hF);
      br_req  <= c[0];
      link_up <= c[1];
      repeat (2) @(posedge i_clock);
      check("local ack", 32'(o_local_ack), 32'(c[0] & ~c[1] & c[2]));
    end
    br_req <= 1'b0;
    $display("Test local ack done");
  endtask

  // Empty behaviour and line inversion
  task automatic t_audio();
    logic [1:0] m;
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, LBO_ADR_OUTFMT, 8'(i << 2), 4'hF);
      aud_word  <= 32'hA5C3_3C5A;
      aud_valid <= 1'b1;
      aud_empty <= 1'b0;
      @(posedge i_clock);
      aud_valid <= 1'b0;
      aud_empty <= 1'b1;
      aud_word  <= 32'h1234_5678;
      repeat (3) @(posedge i_clock);
      check("audio", o_aud_word, (i == 0) ? 32'hA5C3_3C5A : 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wb(1'b1, LBO_ADR_OUTFMT, {6'h0, m}, 4'hF);
      lines_in <= '{sck: 1'b1, ws: 1'b0};
      repeat (2) @(posedge i_clock);
      check("sck", 32'(lines_out.sck), 32'(!m[1]));
      check("ws", 32'(lines_out.ws), 32'(m[0]));
    end
    $display("Test audio done");
  endtask

  task automatic t_video();
    vid_in <= '{data: 20'hA5C3E};
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, LBO_ADR_OUTFMT, 8'(i << 3), 4'hF);
      repeat (2) @(posedge i_clock);
      vid_seen[i] = vid_out;
    end
    check("sync 00", 32'(vid_seen[0].data), 32'h000A5C3E);
    check("sync 01", 32'(vid_seen[1].data), 32'h00099C3E);
    check("sync 10", 32'(vid_seen[2].data), 32'h000970F9);
    check("sync 11", 32'(vid_seen[3].data), 32'h000970F9);
    $display("Test sync position done");
  endtask

  // Hang guard, far beyond the 155 cycles the tests need
  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    t_reset();
    t_regs();
    t_bridge();
    t_local_ack();
    t_audio();
    t_video();
    finish_test();
  end
endmodule
